/* adc_regs_pkg.sv */
// Shared constants and types for the converter status and configuration registers
`default_nettype none
package adc_regs_pkg;

  // Register select codes carried in the command byte
  localparam logic [1:0] REG_STATUS_OFS = 2'h0;
  localparam logic [1:0] REG_CONFIG_OFS = 2'h1;
  localparam logic [1:0] REG_FILTER_OFS = 2'h2;
  localparam logic [1:0] REG_DATA_OFS = 2'h3;

  // Configuration register reset value and writable bits
  localparam logic [7:0] CONFIG_RESET = 8'h02;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'hce;

  // Status register fixed fields and reset values
  localparam logic [1:0] STATUS_ZERO_FIELD = 2'h0;
  localparam logic STATUS_ONE_BIT = 1'h1;
  localparam logic PENDING_RESET = 1'h1;
  localparam logic ERROR_RESET = 1'h0;

  // Operating mode field codes
  localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

  // Serial framing
  localparam logic CMD_START_LEVEL = 1'h0;
  localparam logic CMD_DIR_READ = 1'h1;
  localparam logic [2:0] CMD_LAST_BIT = 3'h6;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam int SYNC_WIDTH = 3;

  typedef logic [1:0] operating_mode_t;

  typedef struct packed {
    logic write_enable_n;
    logic must_be_zero;
    logic [1:0] register_select;
    logic read_not_write;
    logic continuous_read;
    logic [1:0] channel_code;
  } command_s;

  typedef struct packed {
    operating_mode_t operating_mode_field;
    logic [1:0] zero_high;
    logic burnout_current_enable;
    logic unipolar;
    logic buffer_enable;
    logic zero_low;
  } config_s;

  typedef struct packed {
    logic result_update_soon;
    logic result_store;
    logic result_clamped;
    logic result_read;
    logic [1:0] channel_code;
  } core_event_s;

endpackage : adc_regs_pkg
`default_nettype wire

/* adc_status_mode_registers.sv */
// Status and configuration registers behind the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Status register is eight bits, read only; writes never change it.
// R2: Host reads status by sending a read command with register select zero.
// R3: Status byte leaves most significant bit first.
// R4: Pending flag clears when a new result is stored.
// R5: Pending flag sets after a result read or just before an update.
// R6: Pending flag sets when power-down mode is entered.
// R7: Data-out pin shows the pending flag while no byte is shifting.
// R8: Clamp error flag updates together with the pending flag.
// R9: Clamp error flag sets when the stored result was saturated.
// R10: Clamp error flag clears on a write that starts a conversion.
// R11: Status bits 5 and 4 read zero, bit 3 reads one.
// R12: Status bit 2 holds a fixed variant identification value.
// R13: Status bits 1 and 0 give the channel being converted.
// R14: Configuration register is eight bits, writable and readable.
// R15: Configuration resets to buffered, continuous, bipolar, burnout off.
// R16: Configuration bytes move most significant bit first both ways.
// R17: Configuration write resets modulator and filter, sets pending flag.
// R18: Mode field 7:6, burnout 3, unipolar 2, buffer 1; others zero.
// R19: Command starts with a zero bit; seven more bits follow.
// R20: Command bit 3 chooses write when zero, read when one.
// R21: Mode codes: 00 continuous, 10 single, 11 power-down, 01 reserved.
module adc_status_mode_registers
  import adc_regs_pkg::*;
#(
  parameter logic VARIANT_ID_BIT = 1'h0 // Arbitrary value
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic cs_n,
  input wire core_event_s core_event,
  output logic dout_rdy_n,
  output config_s config_out,
  output logic modulator_reset,
  output command_s command_out,
  output logic command_stb
);

  typedef enum logic [1:0] {
    ST_HUNT,
    ST_COMMAND,
    ST_WRITE,
    ST_READ
  } port_state_e;

  function automatic logic [7:0] status_byte(
    input logic pending,
    input logic clamp_err,
    input logic [1:0] channel_code
  );
    status_byte = {pending, clamp_err, STATUS_ZERO_FIELD, STATUS_ONE_BIT, // [R11]
                   VARIANT_ID_BIT, channel_code}; // [R12] [R13]
  endfunction : status_byte

  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Serial pins into the clock domain
  logic [SYNC_WIDTH-1:0] pins_raw;
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic sclk_s;
  logic din_s;
  logic cs_n_s;

  assign pins_raw = {sclk, din, cs_n};

  pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign din_s = pins_sync[1];
  assign cs_n_s = pins_sync[0];

  // Serial port state
  port_state_e state_q;
  port_state_e state_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic dout_q;
  logic dout_d;
  logic sclk_prev_q;
  logic sclk_prev_d;
  command_s cmd_q;
  command_s cmd_d;
  logic cmd_stb_q;
  logic cmd_stb_d;
  config_s cfg_q;
  config_s cfg_d;
  logic modrst_q;
  logic modrst_d;
  logic cfg_wr;

  // Flag state
  logic pending_q;
  logic pending_d;
  logic err_q;
  logic err_d;

  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] status_now;
  command_s cmd_new;
  logic [7:0] byte_new;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign status_now = status_byte(pending_q, err_q, core_event.channel_code);
  assign cmd_new = command_s'({CMD_START_LEVEL, shift_q[5:0], din_s});
  assign byte_new = {shift_q[6:0], din_s};

  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    dout_d = (state_q == ST_READ) ? dout_q : pending_q; // [R7]
    sclk_prev_d = sclk_s;
    cmd_d = cmd_q;
    cmd_stb_d = 1'h0;
    cfg_d = cfg_q;
    modrst_d = 1'h0;
    cfg_wr = 1'h0;
    if (cs_n_s) begin
      state_d = ST_HUNT;
      bit_cnt_d = 3'h0;
      dout_d = pending_q;
    end else begin
      unique case (state_q)
        ST_HUNT: begin
          if (sclk_rise && din_s == CMD_START_LEVEL) begin // [R19]
            state_d = ST_COMMAND;
            bit_cnt_d = 3'h0;
            shift_d = 8'h00;
          end
        end
        ST_COMMAND: begin
          if (sclk_rise) begin
            shift_d = byte_new;
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == CMD_LAST_BIT) begin // [R19]
              bit_cnt_d = 3'h0;
              cmd_d = cmd_new;
              cmd_stb_d = 1'h1;
              state_d = ST_HUNT;
              if (cmd_new.read_not_write == CMD_DIR_READ) begin // [R20]
                if (cmd_new.register_select == REG_STATUS_OFS) begin // [R2]
                  shift_d = status_now;
                  state_d = ST_READ;
                end else if (cmd_new.register_select == REG_CONFIG_OFS) begin
                  shift_d = cfg_q;
                  state_d = ST_READ;
                end
              end else if (cmd_new.register_select == REG_CONFIG_OFS) begin // [R20]
                state_d = ST_WRITE;
              end
              // A write with select zero only reloads the command; status stays [R1]
            end
          end
        end
        ST_WRITE: begin
          if (sclk_rise) begin
            shift_d = byte_new; // [R16]
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BYTE_LAST_BIT) begin
              bit_cnt_d = 3'h0;
              cfg_d = config_s'(byte_new & CONFIG_WRITE_MASK); // [R14] [R18]
              cfg_wr = 1'h1;
              modrst_d = 1'h1; // [R17]
              state_d = ST_HUNT;
            end
          end
        end
        ST_READ: begin
          if (sclk_fall) begin
            dout_d = shift_q[7]; // [R3] [R16]
            shift_d = {shift_q[6:0], 1'h0};
          end
          if (sclk_rise) begin
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == BYTE_LAST_BIT) begin
              bit_cnt_d = 3'h0;
              state_d = ST_HUNT;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_HUNT;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      dout_q <= PENDING_RESET;
      sclk_prev_q <= 1'h1;
      cmd_q <= command_s'(8'h00);
      cmd_stb_q <= 1'h0;
      cfg_q <= config_s'(CONFIG_RESET); // [R15]
      modrst_q <= 1'h0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      dout_q <= dout_d;
      sclk_prev_q <= sclk_prev_d;
      cmd_q <= cmd_d;
      cmd_stb_q <= cmd_stb_d;
      cfg_q <= cfg_d;
      modrst_q <= modrst_d;
    end
  end

  // Pending and clamp flags; any set wins over the clear on a store
  always_comb begin
    pending_d = pending_q;
    err_d = err_q;
    if (core_event.result_store) begin
      pending_d = 1'h0; // [R4]
      err_d = core_event.result_clamped; // [R8] [R9]
    end
    if (cfg_wr) begin
      err_d = 1'h0; // [R10]
    end
    if (core_event.result_read || core_event.result_update_soon) begin
      pending_d = 1'h1; // [R5]
    end
    if (cfg_wr || cfg_q.operating_mode_field == MODE_POWER_DOWN) begin
      pending_d = 1'h1; // [R6] [R17] [R21]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= PENDING_RESET;
      err_q <= ERROR_RESET;
    end else begin
      pending_q <= pending_d;
      err_q <= err_d;
    end
  end

  assign dout_rdy_n = dout_q;
  assign config_out = cfg_q;
  assign modulator_reset = modrst_q;
  assign command_out = cmd_q;
  assign command_stb = cmd_stb_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence read_bit_edge;
    state_q == ST_READ && sclk_fall && !cs_n_s;
  endsequence

  sequence status_read_cmd;
    state_q == ST_COMMAND && sclk_rise && !cs_n_s && bit_cnt_q == CMD_LAST_BIT &&
      cmd_new.read_not_write && cmd_new.register_select == REG_STATUS_OFS;
  endsequence

  sequence config_write_done;
    state_q == ST_WRITE && sclk_rise && !cs_n_s && bit_cnt_q == BYTE_LAST_BIT;
  endsequence

  // Last command bit taken, whatever the select
  sequence command_done;
    state_q == ST_COMMAND && sclk_rise && !cs_n_s && bit_cnt_q == CMD_LAST_BIT;
  endsequence

  chk_status_fixed_bits: assert property ( // [R11] [R12] [R13]
    status_read_cmd |=> shift_q[5:0] == {STATUS_ZERO_FIELD, STATUS_ONE_BIT, VARIANT_ID_BIT,
      $past(core_event.channel_code)})
    else $error("status fixed bits wrong");

  chk_status_load: assert property (status_read_cmd |=> shift_q == $past(status_now) && state_q == ST_READ) // [R2]
    else $error("status byte not loaded for read");

  chk_read_msb_first: assert property (read_bit_edge |=> dout_q == $past(shift_q[7])) // [R3]
    else $error("read bit order wrong");

  chk_store_clears: assert property ( // [R4]
    core_event.result_store && !core_event.result_read && !core_event.result_update_soon && !cfg_wr &&
      cfg_q.operating_mode_field != MODE_POWER_DOWN |=> !pending_q)
    else $error("pending not cleared on store");

  chk_read_sets: assert property (core_event.result_read || core_event.result_update_soon |=> pending_q) // [R5]
    else $error("pending not set on read or update");

  chk_pdown_sets: assert property (cfg_q.operating_mode_field == MODE_POWER_DOWN |=> pending_q) // [R6]
    else $error("pending not held in power-down");

  chk_idle_pin_ready: assert property (state_q != ST_READ |=> dout_rdy_n == $past(pending_q)) // [R7]
    else $error("ready pin does not follow pending");

  chk_err_with_store: assert property ( // [R8] [R9]
    core_event.result_store && !cfg_wr |=> err_q == $past(core_event.result_clamped))
    else $error("clamp flag not written with store");

  chk_err_cleared: assert property (config_write_done |=> !err_q) // [R10]
    else $error("clamp flag not cleared by write");

  chk_config_reset: assert property ($rose(rst_n) |-> cfg_q == config_s'(CONFIG_RESET)) // [R15]
    else $error("configuration reset value wrong");

  chk_config_write: assert property ( // [R14] [R16] [R17]
    config_write_done |=> modulator_reset && pending_q && cfg_q == config_s'($past(byte_new) & CONFIG_WRITE_MASK)
      ##1 !modulator_reset)
    else $error("configuration write effects wrong");

  chk_config_rsvd: assert property ((cfg_q & ~CONFIG_WRITE_MASK) == 8'h00) // [R18]
    else $error("reserved configuration bits set");

  chk_cmd_start: assert property ( // [R19] [R20]
    state_q == ST_HUNT && sclk_rise && !cs_n_s && din_s |=> state_q == ST_HUNT)
    else $error("command started without zero bit");

  // One strobe per completed command, carrying the byte just taken
  chk_cmd_strobe: assert property ( // [R19] [R20]
    command_done |=> command_stb && command_out == $past(cmd_new) ##1 !command_stb)
    else $error("command strobe or capture wrong");

endmodule : adc_status_mode_registers
`default_nettype wire

/* adc_status_mode_registers_bench.sv */
// Self-checking bench for the status and configuration registers
`timescale 1ns/1ps
`default_nettype none
module adc_status_mode_registers_bench;
  import adc_regs_pkg::*;
  localparam logic VARIANT = 1'h0; // Arbitrary value
  logic clk, arst_n, sclk, din, cs_n, dout_rdy_n, mod_rst, cmd_stb;
  core_event_s ce;
  config_s cfg;
  command_s cmd_q;
  int fails = 0, checks = 0, mr_cnt = 0, exp_mr = 0, stb_cnt = 0, exp_stb = 0;
  logic exp_pend = 1'b1, exp_clamp = 1'b0;
  logic [7:0] exp_cfg = 8'h02, rx, v;

  adc_status_mode_registers #(.VARIANT_ID_BIT(VARIANT)) i_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk),
    .din(din), .cs_n(cs_n), .core_event(ce), .dout_rdy_n(dout_rdy_n), .config_out(cfg),
    .modulator_reset(mod_rst), .command_out(cmd_q), .command_stb(cmd_stb));
  serial_host i_host (.clk(clk), .dout_rdy_n(dout_rdy_n), .sclk(sclk), .din(din), .cs_n(cs_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mod_rst === 1'b1) mr_cnt <= mr_cnt + 1;
    if (cmd_stb === 1'b1) stb_cnt <= stb_cnt + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("Counts: checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] exp_status();
    return {exp_pend, exp_clamp, 2'h0, 1'h1, VARIANT, ce.channel_code};
  endfunction : exp_status

  // Ones ahead of the command must be ignored while the port hunts
  task automatic access(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    i_host.frame_start();
    i_host.xfer(8'hff, rd);
    i_host.xfer(cmd, rd);
    check(cmd_q, cmd);
    exp_stb++;
    check(8'(stb_cnt), 8'(exp_stb));
    i_host.xfer(wd, rd);
    i_host.frame_end();
  endtask : access

  task automatic write_cfg(input logic [7:0] wd);
    access(8'h10, wd, rx);
    exp_cfg = wd & 8'hce;
    exp_pend = 1'b1;
    exp_clamp = 1'b0;
    exp_mr++;
    check(cfg, exp_cfg);
    check(8'(mr_cnt), 8'(exp_mr));
    access(8'h18, 8'h00, rx);
    check(rx, exp_cfg);
  endtask : write_cfg

  task automatic read_status;
    access(8'h08, 8'h00, rx);
    check(rx, exp_status());
  endtask : read_status

  // Kind 0 stores a result, 1 warns of an update, 2 reports a read
  task automatic pulse(input int kind, input logic clamp);
    @(posedge clk);
    ce.result_store <= (kind == 0);
    ce.result_clamped <= clamp;
    ce.result_update_soon <= (kind == 1);
    ce.result_read <= (kind == 2);
    @(posedge clk);
    ce.result_store <= 1'b0;
    ce.result_update_soon <= 1'b0;
    ce.result_read <= 1'b0;
    if (kind == 0) begin
      exp_clamp = clamp;
      if (exp_cfg[7:6] != MODE_POWER_DOWN) exp_pend = 1'b0;
    end else begin
      exp_pend = 1'b1;
    end
    repeat (3) @(posedge clk);
    check(dout_rdy_n, exp_pend);
  endtask : pulse

  initial begin
    arst_n = 1'b0;
    ce = '0;
    #300us;
    fails++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hc272));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(cfg, 8'h02);
    check(dout_rdy_n, 1'b1);
    ce.channel_code <= 2'($urandom);
    read_status();
    access(8'h18, 8'h00, rx);
    check(rx, 8'h02);
    $display("test reset_values done");

    for (int c = 0; c < 2; c++) begin
      pulse(0, c[0]);
      ce.channel_code <= 2'($urandom);
      read_status();
      pulse(1, 1'b0);
      pulse(0, c[0]);
      pulse(2, 1'b0);
    end
    $display("test core_events done");

    foreach (v[i]) v[i] = 1'b0;
    for (int m = 0; m < 4; m++) begin
      pulse(0, 1'b1);
      v = 8'($urandom);
      v[7:6] = (m == 0) ? MODE_CONTINUOUS : (m == 1) ? MODE_SINGLE : (m == 2) ? MODE_POWER_DOWN : MODE_RESERVED;
      write_cfg(v);
      if (v[7:6] == MODE_POWER_DOWN) pulse(0, 1'b1);
      read_status();
    end
    $display("test config_modes done");

    pulse(0, 1'b1);
    access(8'h00, 8'hff, rx);
    access(8'h20, 8'hff, rx);
    read_status();
    check(cfg, exp_cfg);
    $display("test status_write done");
    stop_test();
  end
endmodule : adc_status_mode_registers_bench
`default_nettype wire

/* pin_sync.sv */
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  always_comb begin
    meta_d = pin_in;
    stable_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      stable_q <= '1;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign pin_out = stable_q;
endmodule : pin_sync
`default_nettype wire

/* serial_host.sv */
// Host model that drives the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input wire logic clk,
  input wire logic dout_rdy_n,
  output logic sclk,
  output logic din,
  output logic cs_n
);
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    cs_n = 1'b1;
  end

  // Msb first both ways; din moves on the fall, device takes it on the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      sclk <= 1'b0;
      din <= tx[i];
      repeat (8) @(posedge clk);
      rx[i] = dout_rdy_n;
      sclk <= 1'b1;
      repeat (7) @(posedge clk);
    end
  endtask : xfer

  task automatic frame_start;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : frame_start

  // Released data line must not keep its last level
  task automatic frame_end;
    @(posedge clk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (6) @(posedge clk);
  endtask : frame_end
endmodule : serial_host
`default_nettype wire
